// File: hdl/ingress_queue_map_policer.sv
/*
 * Per-port ingress queue mapping, policing control and packet monitor
 * counting for a three-port switch, with APB register access.
 * Assumes packet inputs come from same-clock logic (meter, classifier).
 */
// The APB interface to the registers was decided locally.
// Overview of operation
// R1: Each port holds eight 4-bit fields, field p at bits 4p+3:4p, giving queue.
// R2: Only the low two bits of each field choose the queue.
// R3: Reset maps priorities 7,6 to 3; 5,4 to 2; 3,2 to 1; 1,0 to 0.
// R4: Bit 0 enables policing and early drop together; off after reset.
// R5: Bit 1 chooses color-blind (1) or color-aware (0) metering.
// R6: Bit 2 allows SRP packets to be dropped; clear exempts them.
// R7: Bit 3 remaps the DSCP-derived color in color-aware mode.
// R8: Bit 4 enables marking the policing color into DSCP.
// R9: Bits 6:5 give the color of non-IP frames, reset 01.
// R10: Bit 7 polices per port; clear uses port index 0 rates per queue.
// R11: Bits 9:8 pick monitor type: 11 red, 10 yellow, 01 green, 00 dropped.
// R12: Bit 10 drops all while over maximum; clear uses random drop decision.
// R13: Bit 11 counts only dropped packets of a color; clear counts all.
// R14: Pointer holds port index at 18:16 and queue at 1:0.
// R15: With policing off nothing is dropped or recolored; mapping still applies.
// R16: Software sets the pointer before reading the monitor counter.
`timescale 1ns/1ps
module ingress_queue_map_policer
    import qos_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic pkt_valid,
    input wire pkt_in_t pkt,
    output logic pkt_ready,
    output logic dec_valid,
    output decision_t dec
);

    // ************************************************************
    // State
    // ************************************************************
    // All block state in one record
    typedef struct packed {
        logic [NUM_PORTS-1:0][31:0] prio_map;
        logic [NUM_PORTS-1:0][POL_W-1:0] police;
        logic [2:0] ptr_port;
        logic [1:0] ptr_queue;
        cnt_state_t st;
        logic [CNT_IDX_W-1:0] idx_first;
        logic [CNT_IDX_W-1:0] idx_second;
        logic inc_second;
        logic mon_ready;
        logic [31:0] rdata;
        logic dec_valid;
        decision_t dec;
    } state_t;

    state_t cur;
    state_t nxt;

    // Counter store hookup
    logic [CNT_W-1:0] ram_rd_a;
    logic [CNT_W-1:0] ram_rd_b;
    logic ram_wr_en;
    logic [CNT_IDX_W-1:0] ram_wr_addr;
    logic [CNT_W-1:0] ram_wr_data;
    logic [CNT_IDX_W-1:0] ram_rd_addr_a;
    logic [CNT_IDX_W-1:0] ram_rd_addr_b;

    // ************************************************************
    // Helpers
    // ************************************************************
    // Counter index from port, queue and type
    // Type 00 is the drop count; colors never alias it
    function automatic logic [CNT_IDX_W-1:0] cnt_index(input logic [1:0] port,
                                                      input logic [1:0] queue,
                                                      input logic [1:0] kind);
        cnt_index = {port, queue, kind};
    endfunction

    // Police control of a port; out-of-range ports read as reset value
    // Software may aim the pointer past the last port
    function automatic logic [POL_W-1:0] police_of(input state_t s, input logic [2:0] port);
        police_of = POLICE_RESET;
        if (port < 3'(NUM_PORTS)) begin
            police_of = s.police[port[1:0]];
        end
    endfunction

    // Worse of two colors; red outranks yellow outranks green
    // Codes rise with severity, so a compare suffices
    function automatic logic [1:0] worse(input logic [1:0] a, input logic [1:0] b);
        worse = (a > b) ? a : b;
    endfunction

    // ************************************************************
    // APB decode
    // ************************************************************
    // Address fields of the current transfer
    logic [3:0] acc_port_n;
    logic [11:0] acc_ofs;
    logic port_ok;
    logic [1:0] acc_idx;
    logic hit_ptr;
    logic hit_map;
    logic hit_pol;
    logic hit_mon;
    logic acc_phase;

    // Top nibble is the port; offsets repeat per port
    always_comb begin
        acc_port_n = paddr[ADDR_W-1:ADDR_W-4];
        acc_ofs = paddr[11:0];
        port_ok = (acc_port_n >= PORT_FIRST) && (acc_port_n <= PORT_LAST);
        acc_idx = 2'(acc_port_n - PORT_FIRST);
        hit_ptr = port_ok && (acc_ofs == OFS_POINTER);
        hit_map = port_ok && (acc_ofs == OFS_PRIO_MAP);
        hit_pol = port_ok && (acc_ofs == OFS_POLICE);
        hit_mon = port_ok && (acc_ofs == OFS_MONITOR);
        acc_phase = psel && penable;
    end

    // Monitor reads wait one cycle for the registered counter word
    // Other accesses never wait
    always_comb begin
        pready = !(hit_mon && !pwrite && !cur.mon_ready);
        pslverr = acc_phase && pready && !(hit_ptr || hit_map || hit_pol || hit_mon);
        prdata = cur.rdata;
    end

    // ************************************************************
    // Packet decision
    // ************************************************************
    logic [POL_W-1:0] pkt_pol;
    logic [1:0] in_color;
    logic [1:0] policed_color;
    logic early_drop;
    decision_t pkt_dec;
    logic count_color;

    // Result is registered on the taking edge
    // The classifier never presents port 3
    always_comb begin
        pkt_pol = police_of(cur, {1'b0, pkt.port});
        // R1: map field by priority
        // R2: low two bits only
        pkt_dec.queue = cur.prio_map[pkt.port][MAP_FIELD_W*pkt.priority_value +: 2];
        // R9: non-IP color
        // Non-IP frames carry no DSCP
        // R7: DSCP remap
        if (!pkt.is_ip) begin
            in_color = pkt_pol[POL_NONIP_LO +: 2];
        end else if (pkt_pol[POL_REMAP]) begin
            in_color = pkt.remap_color;
        end else begin
            in_color = pkt.dscp_color;
        end
        // R5: blind or aware metering
        if (pkt_pol[POL_BLIND]) begin
            policed_color = pkt.meter_color;
        end else begin
            policed_color = worse(in_color, pkt.meter_color);
        end
        // R12: drop all or random drop
        early_drop = pkt_pol[POL_DROP_ALL] ? pkt.early_drop_over_max : pkt.early_drop_random;
        // R6: SRP exemption
        // Reserved streams are spared by default
        if (pkt.is_srp && !pkt_pol[POL_DROP_SRP]) begin
            early_drop = 1'b0;
        end
        // R4: one enable for policing and early drop
        // R15: disabled means no drop or recolor
        if (pkt_pol[POL_ENABLE]) begin
            pkt_dec.color = policed_color;
            pkt_dec.drop = early_drop;
            // R8: DSCP color marking
            pkt_dec.mark_dscp = pkt_pol[POL_MARK];
        end else begin
            // Input color passes untouched
            pkt_dec.color = in_color;
            pkt_dec.drop = 1'b0;
            pkt_dec.mark_dscp = 1'b0;
        end
        // R10: aggregate rates use port index 0
        // Port 0 rate settings serve all ports then
        pkt_dec.rate_port = pkt_pol[POL_PORT_BASED] ? pkt.port : 2'h0;
        // R13: dropped-only color counting
        // Color 00 has no counter of its own
        count_color = (pkt_dec.color != TYPE_DROPPED)
                      && (!pkt_pol[POL_DROPPED_ONLY] || pkt_dec.drop);
    end

    // ************************************************************
    // Next state
    // ************************************************************
    // Police control of the pointed port
    logic [POL_W-1:0] ptr_pol;

    // A counted packet holds the input one or two cycles
    always_comb begin
        nxt = cur;
        ram_wr_en = 1'b0;
        ram_wr_addr = cur.idx_first;
        ram_wr_data = ram_rd_a + 32'h0000_0001;
        ram_rd_addr_a = cur.idx_second;
        ptr_pol = police_of(cur, cur.ptr_port);
        // R11: monitor type from the pointed port
        // R16: pointer chooses the counter read
        ram_rd_addr_b = cnt_index(cur.ptr_port[1:0], cur.ptr_queue, ptr_pol[POL_TYPE_LO +: 2]);
        pkt_ready = (cur.st == ST_IDLE);
        nxt.dec_valid = 1'b0;

        // Register writes take effect in the completing access cycle
        // A refused access decodes no hit and changes nothing
        if (acc_phase && pready && pwrite) begin
            // R14: pointer fields
            if (hit_ptr) begin
                nxt.ptr_port = pwdata[PTR_PORT_LO +: 3];
                nxt.ptr_queue = pwdata[PTR_QUEUE_LO +: 2];
            end
            // Reserved map bits are kept as written
            if (hit_map) begin
                nxt.prio_map[acc_idx] = pwdata;
            end
            // Bits above the control field read as zero
            if (hit_pol) begin
                nxt.police[acc_idx] = pwdata[POL_W-1:0];
            end
        end

        // Read data captured for the next completing read
        nxt.mon_ready = acc_phase && hit_mon && !pwrite && !cur.mon_ready;
        if (psel && !penable) begin
            nxt.rdata = '0;
            if (hit_ptr) begin
                nxt.rdata[PTR_PORT_LO +: 3] = cur.ptr_port;
                nxt.rdata[PTR_QUEUE_LO +: 2] = cur.ptr_queue;
            end
            if (hit_map) begin
                nxt.rdata = cur.prio_map[acc_idx];
            end
            if (hit_pol) begin
                nxt.rdata[POL_W-1:0] = cur.police[acc_idx];
            end
        end
        // Counter word is taken in the first access cycle so that it
        // stands on prdata in the completing one
        if (nxt.mon_ready) begin
            nxt.rdata = ram_rd_b;
        end

        // Counter update: read, then write the word plus one
        // Reads are registered, hence separate write states
        case (cur.st)
            ST_IDLE: begin
                if (pkt_valid) begin
                    nxt.dec = pkt_dec;
                    nxt.dec_valid = 1'b1;
                    nxt.inc_second = count_color && pkt_dec.drop;
                    nxt.idx_second = cnt_index(pkt.port, pkt_dec.queue, TYPE_DROPPED);
                    if (count_color) begin
                        nxt.idx_first = cnt_index(pkt.port, pkt_dec.queue, pkt_dec.color);
                    end else begin
                        nxt.idx_first = cnt_index(pkt.port, pkt_dec.queue, TYPE_DROPPED);
                    end
                    ram_rd_addr_a = nxt.idx_first;
                    // Nothing to count keeps the machine idle
                    if (count_color || pkt_dec.drop) begin
                        nxt.st = ST_WR_FIRST;
                    end
                end
            end
            ST_WR_FIRST: begin
                // Second word is read now for the next write
                ram_wr_en = 1'b1;
                ram_rd_addr_a = cur.idx_second;
                nxt.idx_first = cur.idx_second;
                nxt.st = cur.inc_second ? ST_WR_SECOND : ST_IDLE;
            end
            ST_WR_SECOND: begin
                // Drop count of the same packet
                ram_wr_en = 1'b1;
                nxt.st = ST_IDLE;
            end
            default: begin
                // Unused codes fall back to idle
                nxt.st = ST_IDLE;
            end
        endcase
    end

    // ************************************************************
    // Registers
    // ************************************************************
    // Reset values; R3 default queue map lives in the package constant
    // Counters are not reset; they start at zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            // R3: default priority map
            cur.prio_map <= {NUM_PORTS{PRIO_MAP_RESET}};
            // R4: policing off at reset
            cur.police <= {NUM_PORTS{POLICE_RESET}};
            cur.ptr_port <= '0;
            cur.ptr_queue <= '0;
            cur.st <= ST_IDLE;
            cur.idx_first <= '0;
            cur.idx_second <= '0;
            cur.inc_second <= 1'b0;
            cur.mon_ready <= 1'b0;
            cur.rdata <= '0;
            cur.dec_valid <= 1'b0;
            cur.dec <= '0;
        end else begin
            cur <= nxt;
        end
    end

    // Decision outputs come from flip-flops
    always_comb begin
        dec_valid = cur.dec_valid;
        dec = cur.dec;
    end

    // ************************************************************
    // Counter store
    // ************************************************************
    // Port a serves packets, port b the monitor
    monitor_counter_ram u_counters (
        .pclk(pclk),
        .wr_en(ram_wr_en),
        .wr_addr(ram_wr_addr),
        .wr_data(ram_wr_data),
        .rd_addr_a(ram_rd_addr_a),
        .rd_data_a(ram_rd_a),
        .rd_addr_b(ram_rd_addr_b),
        .rd_data_b(ram_rd_b)
    );

endmodule

// File: hdl/monitor_counter_ram.sv
/*
 * Counter store for the packet monitor: one write port, two read ports,
 * read data registered. Assumes single clock and that the writer never
 * needs a word it writes in the same cycle.
 */
`timescale 1ns/1ps
module monitor_counter_ram
    import qos_pkg::*;
(
    input wire logic pclk,
    input wire logic wr_en,
    input wire logic [CNT_IDX_W-1:0] wr_addr,
    input wire logic [CNT_W-1:0] wr_data,
    input wire logic [CNT_IDX_W-1:0] rd_addr_a,
    output logic [CNT_W-1:0] rd_data_a,
    input wire logic [CNT_IDX_W-1:0] rd_addr_b,
    output logic [CNT_W-1:0] rd_data_b
);

    // ************************************************************
    // Storage
    // ************************************************************
    logic [CNT_W-1:0] mem [0:(1<<CNT_IDX_W)-1];

    // Cleared at start so every count begins at zero
    initial begin
        for (int i = 0; i < (1 << CNT_IDX_W); i++) begin
            mem[i] = '0;
        end
    end

    // Write and registered reads
    always_ff @(posedge pclk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data_a <= mem[rd_addr_a];
        rd_data_b <= mem[rd_addr_b];
    end

endmodule

// File: hdl/qos_pkg.sv
/*
 * Shared constants and types for the ingress queue mapping and policing block.
 * Assumes a 16-bit APB byte address whose top nibble carries the port number.
 */
package qos_pkg;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [11:0] OFS_POINTER = 12'h804;
    localparam logic [11:0] OFS_PRIO_MAP = 12'h808;
    localparam logic [11:0] OFS_POLICE = 12'h80C;
    localparam logic [11:0] OFS_MONITOR = 12'h810;
    localparam logic [3:0] PORT_FIRST = 4'h1;
    localparam logic [3:0] PORT_LAST = 4'h3;
    localparam int NUM_PORTS = 3;
    localparam int ADDR_W = 16;

    // ************************************************************
    // Field layout and reset values
    // ************************************************************
    localparam logic [31:0] PRIO_MAP_RESET = 32'h3322_1100;
    localparam logic [11:0] POLICE_RESET = 12'h020;
    localparam int POL_ENABLE = 0;
    localparam int POL_BLIND = 1;
    localparam int POL_DROP_SRP = 2;
    localparam int POL_REMAP = 3;
    localparam int POL_MARK = 4;
    localparam int POL_NONIP_LO = 5;
    localparam int POL_PORT_BASED = 7;
    localparam int POL_TYPE_LO = 8;
    localparam int POL_DROP_ALL = 10;
    localparam int POL_DROPPED_ONLY = 11;
    localparam int POL_W = 12;
    localparam int PTR_PORT_LO = 16;
    localparam int PTR_QUEUE_LO = 0;
    localparam int MAP_FIELD_W = 4;

    // ************************************************************
    // Colors double as monitor type codes; 00 is the drop count
    // ************************************************************
    localparam logic [1:0] TYPE_DROPPED = 2'h0;
    localparam logic [1:0] COLOR_GREEN = 2'h1;
    localparam logic [1:0] COLOR_YELLOW = 2'h2;
    localparam logic [1:0] COLOR_RED = 2'h3;
    localparam int CNT_W = 32;
    localparam int CNT_IDX_W = 6;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_WR_FIRST = 3'b010,
        ST_WR_SECOND = 3'b100
    } cnt_state_t;

    // Packet presented by the classifier and meter
    typedef struct packed {
        logic [1:0] port;
        logic [2:0] priority_value;
        logic is_ip;
        logic is_srp;
        logic [1:0] dscp_color;
        logic [1:0] remap_color;
        logic [1:0] meter_color;
        logic early_drop_over_max;
        logic early_drop_random;
    } pkt_in_t;

    // Decision returned for that packet
    typedef struct packed {
        logic [1:0] queue;
        logic [1:0] color;
        logic drop;
        logic mark_dscp;
        logic [1:0] rate_port;
    } decision_t;

endpackage

// File: testbench/qos_checker.sv
/*
 * Concurrent checks for the queue map and policing block.
 * Assumes it is bound to the block top and sees only its ports.
 */
`timescale 1ns/1ps
module qos_checker
    import qos_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic pkt_valid,
    input wire pkt_in_t pkt,
    input wire logic pkt_ready,
    input wire logic dec_valid,
    input wire decision_t dec
);
    // ************************************************************
    // Shadow of the policing control registers
    // ************************************************************
    // Only completed, accepted writes land, as in the block itself
    logic [11:0] pol [4];
    logic [1:0] n;
    logic take;
    logic en;
    logic mk;
    logic [1:0] rsel;
    assign n = pkt.port + 2'h1;
    assign take = pkt_valid && pkt_ready;
    assign en = pol[n][POL_ENABLE];
    assign mk = pol[n][POL_MARK];
    assign rsel = pol[n][POL_PORT_BASED] ? pkt.port : 2'h0;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pol <= '{default: POLICE_RESET};
        end else if (psel && penable && pready && pwrite && !pslverr
                     && paddr[11:0] == OFS_POLICE) begin
            pol[paddr[13:12]] <= pwdata[11:0];
        end
    end

    // ************************************************************
    // Properties
    // ************************************************************
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_mon_setup;
        psel && !penable && !pwrite && paddr[11:0] == OFS_MONITOR;
    endsequence
    sequence s_two_stall;
        !pkt_ready ##1 !pkt_ready ##1 pkt_ready;
    endsequence
    property p_take;
        take |=> dec_valid;
    endproperty
    a_take: assert property (p_take)
        else $error("no decision after packet");
    property p_hold;
        !dec_valid |-> $stable(dec);
    endproperty
    a_hold: assert property (p_hold)
        else $error("decision changed without pulse");
    property p_off;
        take && !en |=> !dec.drop && !dec.mark_dscp;
    endproperty
    a_off: assert property (p_off)
        else $error("drop or mark with policing off");
    property p_mark;
        take && en |=> dec.mark_dscp == $past(mk);
    endproperty
    a_mark: assert property (p_mark)
        else $error("mark flag wrong");
    property p_rate;
        take |=> dec.rate_port == $past(rsel);
    endproperty
    a_rate: assert property (p_rate)
        else $error("rate port wrong");
    property p_stall2;
        dec_valid && dec.drop && dec.color != 2'h0 |-> s_two_stall;
    endproperty
    a_stall2: assert property (p_stall2)
        else $error("two counter writes expected");
    property p_wait;
        s_mon_setup ##1 (psel && penable) |-> !pready ##1 pready;
    endproperty
    a_wait: assert property (p_wait)
        else $error("monitor read wait state wrong");
    property p_fast;
        psel && penable && paddr[11:0] != OFS_MONITOR |-> pready;
    endproperty
    a_fast: assert property (p_fast)
        else $error("register access stalled");
    property p_err;
        psel && penable && pready && (paddr[15:12] < PORT_FIRST
            || paddr[15:12] > PORT_LAST) |-> pslverr;
    endproperty
    a_err: assert property (p_err)
        else $error("bad port not refused");
endmodule

bind ingress_queue_map_policer qos_checker u_qos_checker (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pkt_valid(pkt_valid), .pkt(pkt),
    .pkt_ready(pkt_ready), .dec_valid(dec_valid), .dec(dec)
);

// File: testbench/tb_ingress_queue_map_policer.sv
/*
 * Self-checking bench for the queue map and policing block.
 * Assumes the checker is bound in and the package is compiled first.
 */
`timescale 1ns/1ps
module tb_ingress_queue_map_policer
    import qos_pkg::*;
;
    logic pclk, presetn, psel, penable, pwrite, pkt_valid;
    logic [15:0] paddr;
    logic [31:0] pwdata, prdata, r, v;
    logic pready, pslverr, pkt_ready, dec_valid, e;
    pkt_in_t pkt, pk;
    decision_t dec;
    logic [31:0] map [3];
    logic [11:0] pol [3];
    logic [31:0] cnt [3][4][4];
    integer seed, fail_count, cmp_count;
    int cyc = 0;

    ingress_queue_map_policer u_ingress_queue_map_policer (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pkt_valid(pkt_valid), .pkt(pkt),
        .pkt_ready(pkt_ready), .dec_valid(dec_valid), .dec(dec)
    );

    // ************************************************************
    // Clock, hang guard and reporting
    // ************************************************************
    initial begin
        pclk = 1'h0;
        forever #5 pclk = ~pclk;
    end

    // The run needs under two thousand cycles; this only cuts a hang
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fail_count = fail_count + 1;
            test_done;
        end
    end

    task test_done;
        if (fail_count == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task chk(input logic [31:0] g, input logic [31:0] x);
        cmp_count = cmp_count + 1;
        if (g !== x) begin
            fail_count = fail_count + 1;
            $display("mismatch t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask

    // ************************************************************
    // Bus and packet drivers
    // ************************************************************
    // Read data and error are taken in the completing access cycle
    task apb(input logic w, input logic [15:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        @(posedge pclk);
        while (pready !== 1'h1) @(posedge pclk);
        r = prdata;
        e = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask

    function automatic logic [15:0] ad(int n, logic [11:0] o);
        return {4'(n), o};
    endfunction

    function automatic pkt_in_t rnd_pkt();
        pkt_in_t p;
        v = $random(seed);
        p = v[$bits(pkt_in_t)-1:0];
        if (p.port == 2'h3) p.port = 2'h0;
        if (p.dscp_color == 2'h0) p.dscp_color = 2'h2;
        if (p.remap_color == 2'h0) p.remap_color = 2'h3;
        if (p.meter_color == 2'h0) p.meter_color = 2'h1;
        return p;
    endfunction

    // Expected decision: colors order green < yellow < red
    function automatic decision_t exp_dec(pkt_in_t p);
        decision_t d;
        logic [11:0] c;
        logic [1:0] ic;
        c = pol[p.port];
        d = '0;
        d.queue = map[p.port][4*p.priority_value +: 2];
        ic = !p.is_ip ? c[6:5] : (c[3] ? p.remap_color : p.dscp_color);
        d.color = ic;
        if (c[0]) begin
            d.color = c[1] ? p.meter_color : (ic > p.meter_color ? ic : p.meter_color);
            d.drop = (c[10] ? p.early_drop_over_max : p.early_drop_random)
                     && (!p.is_srp || c[2]);
            d.mark_dscp = c[4];
        end
        d.rate_port = c[7] ? p.port : 2'h0;
        return d;
    endfunction

    task send(input pkt_in_t p);
        decision_t x;
        x = exp_dec(p);
        @(posedge pclk);
        pkt_valid <= 1'h1;
        pkt <= p;
        @(posedge pclk);
        while (pkt_ready !== 1'h1) @(posedge pclk);
        pkt_valid <= 1'h0;
        @(negedge pclk);
        chk(32'(dec_valid), 32'h1);
        chk(32'(dec), 32'(x));
        if (x.drop) cnt[p.port][x.queue][0] += 1;
        if (x.color != 2'h0 && (!pol[p.port][11] || x.drop))
            cnt[p.port][x.queue][x.color] += 1;
    endtask

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        int i, p, q, t;
        seed = 10;
        presetn = 1'h0;
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 16'h0;
        pwdata = 32'h0;
        pkt_valid = 1'h0;
        pkt = '0;
        fail_count = 0;
        cmp_count = 0;
        cnt = '{default: 32'h0};
        for (p = 0; p < 3; p++) begin
            map[p] = 32'h3322_1100;
            pol[p] = 12'h020;
        end
        repeat (3) @(posedge pclk);
        presetn <= 1'h1;
        for (p = 1; p < 4; p++) begin
            apb(1'h0, ad(p, OFS_PRIO_MAP), 32'h0);
            chk(r, 32'h3322_1100);
            apb(1'h0, ad(p, OFS_POLICE), 32'h0);
            chk(r, 32'h0000_0020);
            apb(1'h0, ad(p, OFS_POINTER), 32'h0);
            chk(r, 32'h0);
        end
        // Refused places: port 0, port 4, unmapped offset
        apb(1'h1, 16'h0808, 32'hFFFF_FFFF);
        chk(32'(e), 32'h1);
        apb(1'h1, 16'h4808, 32'hFFFF_FFFF);
        chk(32'(e), 32'h1);
        apb(1'h0, 16'h1900, 32'h0);
        chk(r, 32'h0);
        chk(32'(e), 32'h1);
        for (i = 0; i < 2; i++) begin
            for (p = 0; p < 3; p++) begin
                for (q = 0; q < 8; q++) begin
                    pk = rnd_pkt();
                    pk.port = 2'(p);
                    pk.priority_value = 3'(q);
                    send(pk);
                end
                map[p] = $random(seed);
                apb(1'h1, ad(p + 1, OFS_PRIO_MAP), map[p]);
                apb(1'h0, ad(p + 1, OFS_PRIO_MAP), 32'h0);
                chk(r, map[p]);
            end
        end
        repeat (150) begin
            if (($random(seed) & 3) == 0) begin
                p = $unsigned($random(seed)) % 3;
                v = $random(seed);
                pol[p] = v[11:0];
                apb(1'h1, ad(p + 1, OFS_POLICE), v);
                apb(1'h0, ad(p + 1, OFS_POLICE), 32'h0);
                chk(r, {20'h0, pol[p]});
            end
            send(rnd_pkt());
        end
        // Every port, queue and monitor type, pointer set from any port
        for (p = 0; p < 3; p++) begin
            for (q = 0; q < 4; q++) begin
                for (t = 0; t < 4; t++) begin
                    apb(1'h1, ad(q % 3 + 1, OFS_POINTER), {13'h0, 3'(p), 14'h0, 2'(q)});
                    pol[p][9:8] = 2'(t);
                    apb(1'h1, ad(p + 1, OFS_POLICE), {20'h0, pol[p]});
                    apb(1'h0, ad(t % 3 + 1, OFS_MONITOR), 32'h0);
                    chk(r, cnt[p][q][t]);
                end
            end
        end
        apb(1'h0, ad(1, OFS_POINTER), 32'h0);
        chk(r, 32'h0002_0003);
        test_done;
    end
endmodule
